//--- pmr_regs.sv
// Holding-register bank of a humidity and temperature probe.
// Assumes a frame engine on sys_clk that issues one transaction at a time.
// What this block does
// - Each 32-bit value uses two registers: low half first, high half next.
// - Float pairs carry IEEE binary32 encoded values.
// - Both halves go in one transaction; pair read or written coherently.
// - Unavailable float values read as a quiet NaN.
// - One read may span many registers, including undefined addresses.
// - Undefined addresses read as NaN or zero, never fail.
// - Read-only registers ignore writes.
// - Write-only registers accept writes but read as zero.
// - Single-register integers are signed 16-bit two's complement.
// - Two-register integers are signed 32-bit two's complement.
// - Error flags pair is 32 independent single-bit indicators.
// - Smoothing factor float lies between 0.001 and 1.000.
// - Writing one to the restart register restarts the device.
// - Bit rate, frame format, protocol take effect after next restart.
// - Bit-rate code 0..8 maps 300 up to 57600 bits per second.
// - Frame code picks parity, data and stop bits; 8..13 use 7 bits.
// - Protocol code: 0 command, 1 auto, 2 polled, 5 analog, 6 Modbus.
// - Modbus RTU needs 8 data bits and at least 9600 bits per second.
// - Settings hash changes on every settings modification.
// - Humidity and dew point registers exist only on some build variants.
// - Bank reached by read-holding and write-multiple register functions.
`timescale 1ns/1ns
module pmr_regs
    import pmr_pkg::*;
#(
    parameter bit HAS_HUMIDITY = 1'b1
) (
    input wire logic sys_clk,
    input wire logic rst,
    // Transaction from the frame engine; one request per cycle at most
    input wire logic txn_start,
    input wire logic txn_end,
    input wire logic rd_req,
    input wire logic wr_req,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] wr_data,
    output logic rd_valid,
    output logic [15:0] rd_data,
    output logic wr_reject,
    // Measurement side
    input wire logic [31:0] humidity_in,
    input wire logic [31:0] temperature_in,
    input wire logic [31:0] dew_point_in,
    input wire logic meas_valid,
    input wire logic [31:0] error_flags_in,
    // Settings in force and restart
    output logic [15:0] node_address,
    output logic [15:0] reply_delay,
    output logic [3:0] active_baud,
    output pmr_parity_t active_parity,
    output logic active_seven_bits,
    output logic active_two_stop,
    output pmr_proto_t active_protocol,
    output logic active_modbus_ok,
    output logic restart_pulse
);

////////////////////////////////////////////////////////////////////////
// Stored settings

    logic [31:0] smooth_r;
    logic [15:0] smooth_lo_hold_r;
    logic smooth_lo_seen_r;
    logic [15:0] baud_r;
    logic [15:0] frame_r;
    logic [15:0] proto_r;
    logic [15:0] node_r;
    logic [15:0] delay_r;
    logic [31:0] hash_r;
    logic [31:0] snap_r;
    logic snap_ok_r;
    logic [15:0] rd_data_nxt;
    logic setting_changed;
    logic restart_req;
    logic [31:0] smooth_cand;

    assign smooth_cand = {wr_data, smooth_lo_hold_r};
    assign restart_req = wr_req && reg_addr == PMR_ADDR_RESTART && wr_data == PMR_RESTART_CMD;

    // Low half is held until the high half of the same transaction lands
    always_ff @(posedge sys_clk) begin
        if (rst || txn_start || txn_end) begin
            smooth_lo_seen_r <= 1'b0;
            smooth_lo_hold_r <= 16'h0000;
        end else if (wr_req && reg_addr == PMR_ADDR_SMOOTH_LO) begin
            smooth_lo_seen_r <= 1'b1;
            smooth_lo_hold_r <= wr_data;
        end
    end

    // Positive floats compare like integers, so a range check needs no FPU
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            smooth_r <= PMR_SMOOTH_RST;
        end else if (wr_req && reg_addr == PMR_ADDR_SMOOTH_HI && smooth_lo_seen_r
                     && smooth_cand >= PMR_SMOOTH_MIN && smooth_cand <= PMR_SMOOTH_MAX) begin
            smooth_r <= smooth_cand;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            node_r <= PMR_NODE_RST;
            baud_r <= PMR_BAUD_RST;
            frame_r <= PMR_FRAME_RST;
            delay_r <= PMR_DELAY_RST;
            proto_r <= PMR_PROTO_RST;
        end else if (wr_req) begin
            if (reg_addr == PMR_ADDR_NODE) begin
                node_r <= wr_data;
            end else if (reg_addr == PMR_ADDR_BAUD) begin
                baud_r <= wr_data;
            end else if (reg_addr == PMR_ADDR_FRAME) begin
                frame_r <= wr_data;
            end else if (reg_addr == PMR_ADDR_DELAY) begin
                delay_r <= wr_data;
            end else if (reg_addr == PMR_ADDR_PROTO) begin
                proto_r <= wr_data;
            end
        end
    end

    // Writes to measurement, status and hash registers land nowhere
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wr_reject <= 1'b0;
        end else begin
            wr_reject <= wr_req && reg_addr < PMR_ADDR_SMOOTH_LO;
        end
    end

    assign setting_changed = wr_req && ((reg_addr >= PMR_ADDR_NODE && reg_addr <= PMR_ADDR_PROTO)
                             || (reg_addr == PMR_ADDR_SMOOTH_HI && smooth_lo_seen_r));

    // Hash is a running mix; any change moves it, rewriting same value too
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            hash_r <= PMR_HASH_RST;
        end else if (setting_changed) begin
            hash_r <= {hash_r[26:0], hash_r[31:27]} + PMR_HASH_STEP + {16'h0000, wr_data};
        end
    end

////////////////////////////////////////////////////////////////////////
// Settings in force: line settings loaded only at restart, node address and delay live

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            restart_pulse <= 1'b0;
        end else begin
            restart_pulse <= restart_req;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            active_baud <= PMR_BAUD_RST[3:0];
            active_parity <= PMR_PAR_NONE;
            active_seven_bits <= 1'b0;
            active_two_stop <= 1'b1;
            active_protocol <= PMR_PROTO_RTU;
            active_modbus_ok <= 1'b1;
        end else if (restart_pulse) begin
            active_baud <= (baud_r <= PMR_BAUD_MAX) ? baud_r[3:0] : PMR_BAUD_RST[3:0];
            active_seven_bits <= frame_r[PMR_FRAME_SEVEN_BIT];
            active_two_stop <= frame_r[0];
            case (frame_r[2:1])
                2'h1: active_parity <= PMR_PAR_EVEN;
                2'h2: active_parity <= PMR_PAR_ODD;
                default: active_parity <= PMR_PAR_NONE;
            endcase
            case (proto_r)
                16'h0000: active_protocol <= PMR_PROTO_CMDLINE;
                16'h0001: active_protocol <= PMR_PROTO_AUTO;
                16'h0002: active_protocol <= PMR_PROTO_POLLED;
                16'h0005: active_protocol <= PMR_PROTO_ANALOG;
                16'h0006: active_protocol <= PMR_PROTO_RTU;
                default: active_protocol <= PMR_PROTO_INVALID;
            endcase
            // Flags a bad combination; the device still obeys it
            active_modbus_ok <= proto_r != PMR_PROTO_MODBUS
                                || (!frame_r[PMR_FRAME_SEVEN_BIT] && baud_r >= PMR_BAUD_MODBUS_MIN
                                    && baud_r <= PMR_BAUD_MAX);
        end
    end

    // Node address and delay are used live by the frame engine
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            node_address <= PMR_NODE_RST;
            reply_delay <= PMR_DELAY_RST;
        end else begin
            node_address <= node_r;
            reply_delay <= (delay_r > PMR_DELAY_MAX) ? PMR_DELAY_MAX : delay_r;
        end
    end

////////////////////////////////////////////////////////////////////////
// Read path with pair snapshot

    logic [31:0] hum_v;
    logic [31:0] temp_v;
    logic [31:0] dew_v;
    logic [31:0] pair_v;
    logic pair_lo;
    logic pair_hi;

    assign hum_v = (HAS_HUMIDITY && meas_valid) ? humidity_in : PMR_QNAN;
    assign temp_v = meas_valid ? temperature_in : PMR_QNAN;
    assign dew_v = (HAS_HUMIDITY && meas_valid) ? dew_point_in : PMR_QNAN;

    // Pair selection by low address; high half comes from the snapshot once a low half is read
    always_comb begin
        pair_v = 32'h00000000;
        pair_lo = 1'b1;
        if (reg_addr == PMR_ADDR_HUM_LO) begin
            pair_v = hum_v;
        end else if (reg_addr == PMR_ADDR_TEMP_LO) begin
            pair_v = temp_v;
        end else if (reg_addr == PMR_ADDR_DEW_LO) begin
            pair_v = dew_v;
        end else if (reg_addr == PMR_ADDR_ERR_LO) begin
            pair_v = error_flags_in;
        end else if (reg_addr == PMR_ADDR_HASH_LO) begin
            pair_v = hash_r;
        end else if (reg_addr == PMR_ADDR_SMOOTH_LO) begin
            pair_v = smooth_r;
        end else begin
            pair_lo = 1'b0;
        end
    end

    assign pair_hi = reg_addr == PMR_ADDR_HUM_HI || reg_addr == PMR_ADDR_TEMP_HI
                     || reg_addr == PMR_ADDR_DEW_HI || reg_addr == PMR_ADDR_ERR_HI
                     || reg_addr == PMR_ADDR_HASH_HI || reg_addr == PMR_ADDR_SMOOTH_HI;

    // Snapshot at low-half read keeps the halves from two different samples
    always_ff @(posedge sys_clk) begin
        if (rst || txn_start) begin
            snap_r <= 32'h00000000;
            snap_ok_r <= 1'b0;
        end else if (rd_req && pair_lo) begin
            snap_r <= pair_v;
            snap_ok_r <= 1'b1;
        end
    end

    always_comb begin
        rd_data_nxt = 16'h0000;
        if (pair_lo) begin
            rd_data_nxt = pair_v[15:0];
        end else if (pair_hi) begin
            if (snap_ok_r) begin
                rd_data_nxt = snap_r[31:16];
            end else if (reg_addr == PMR_ADDR_ERR_HI) begin
                rd_data_nxt = error_flags_in[31:16];
            end else if (reg_addr == PMR_ADDR_HASH_HI) begin
                rd_data_nxt = hash_r[31:16];
            end else begin
                rd_data_nxt = PMR_QNAN[31:16];
            end
        end else if (reg_addr == PMR_ADDR_FAULT) begin
            rd_data_nxt = {15'h0000, error_flags_in == 32'h00000000};
        end else if (reg_addr == PMR_ADDR_NODE) begin
            rd_data_nxt = node_r;
        end else if (reg_addr == PMR_ADDR_BAUD) begin
            rd_data_nxt = baud_r;
        end else if (reg_addr == PMR_ADDR_FRAME) begin
            rd_data_nxt = frame_r;
        end else if (reg_addr == PMR_ADDR_DELAY) begin
            rd_data_nxt = delay_r;
        end else if (reg_addr == PMR_ADDR_PROTO) begin
            rd_data_nxt = proto_r;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rd_valid <= 1'b0;
            rd_data <= 16'h0000;
        end else begin
            rd_valid <= rd_req;
            rd_data <= rd_req ? rd_data_nxt : 16'h0000;
        end
    end

////////////////////////////////////////////////////////////////////////
// Checks

    restart_reg_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
        rd_req && reg_addr == PMR_ADDR_RESTART |=> rd_valid && rd_data == 16'h0000)
        else $error("restart register read not zero");

    restart_fires_a: assert property (@(posedge sys_clk) disable iff (rst)
        wr_req && reg_addr == PMR_ADDR_RESTART && wr_data == PMR_RESTART_CMD |=> restart_pulse)
        else $error("restart not issued");

    baud_deferred_a: assert property (@(posedge sys_clk) disable iff (rst)
        !restart_pulse |=> $stable(active_baud) && $stable(active_protocol))
        else $error("setting applied without restart");

    node_readback_a: assert property (@(posedge sys_clk) disable iff (rst)
        wr_req && reg_addr == PMR_ADDR_NODE |=> node_r == $past(wr_data))
        else $error("node address not stored");

    hash_moves_a: assert property (@(posedge sys_clk) disable iff (rst)
        wr_req && reg_addr == PMR_ADDR_NODE |=> hash_r != $past(hash_r))
        else $error("hash unchanged on setting change");

    nan_unavail_a: assert property (@(posedge sys_clk) disable iff (rst)
        rd_req && reg_addr == PMR_ADDR_TEMP_LO && !meas_valid |=> rd_data == PMR_QNAN[15:0])
        else $error("missing NaN for unavailable value");

    ro_write_ignored_a: assert property (@(posedge sys_clk) disable iff (rst)
        wr_req && reg_addr < PMR_ADDR_SMOOTH_LO |=> hash_r == $past(hash_r) && wr_reject)
        else $error("read-only register changed");

    smooth_range_a: assert property (@(posedge sys_clk) disable iff (rst)
        smooth_r >= PMR_SMOOTH_MIN && smooth_r <= PMR_SMOOTH_MAX)
        else $error("smoothing factor out of range");

    gap_read_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
        rd_req && reg_addr == 16'h0100 |=> rd_valid && rd_data == 16'h0000)
        else $error("undefined address not zero");

    rd_idle_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
        !rd_req |=> !rd_valid && rd_data == 16'h0000)
        else $error("read answer without request");

    wr_accept_area_a: assert property (@(posedge sys_clk) disable iff (rst)
        wr_req && reg_addr >= PMR_ADDR_SMOOTH_LO |=> !wr_reject)
        else $error("writable area write rejected");

    pair_high_snap_a: assert property (@(posedge sys_clk) disable iff (rst)
        rd_req && pair_hi && snap_ok_r |=> rd_data == $past(snap_r[31:16]))
        else $error("high half not from snapshot");

    fault_status_a: assert property (@(posedge sys_clk) disable iff (rst)
        rd_req && reg_addr == PMR_ADDR_FAULT |=> rd_data[0] == ($past(error_flags_in) == 32'h00000000))
        else $error("fault status wrong");

    err_low_half_a: assert property (@(posedge sys_clk) disable iff (rst)
        rd_req && reg_addr == PMR_ADDR_ERR_LO |=> rd_data == $past(error_flags_in[15:0]))
        else $error("error flags low half wrong");

    smooth_pair_only_a: assert property (@(posedge sys_clk) disable iff (rst)
        wr_req && reg_addr == PMR_ADDR_SMOOTH_HI && !smooth_lo_seen_r |=> $stable(smooth_r))
        else $error("smoothing changed by lone high half");

    delay_clamp_a: assert property (@(posedge sys_clk) disable iff (rst)
        reply_delay <= PMR_DELAY_MAX)
        else $error("reply delay above limit");

    restart_only_one_a: assert property (@(posedge sys_clk) disable iff (rst)
        wr_req && reg_addr == PMR_ADDR_RESTART && wr_data != PMR_RESTART_CMD |=> !restart_pulse)
        else $error("restart on wrong value");

    modbus_seven_bad_a: assert property (@(posedge sys_clk) disable iff (rst)
        restart_pulse && proto_r == PMR_PROTO_MODBUS && frame_r[PMR_FRAME_SEVEN_BIT] |=> !active_modbus_ok)
        else $error("seven bit modbus not flagged");

    hum_nan_a: assert property (@(posedge sys_clk) disable iff (rst)
        rd_req && reg_addr == PMR_ADDR_HUM_LO && !meas_valid |=> rd_data == PMR_QNAN[15:0])
        else $error("missing NaN for humidity");

endmodule

//--- pmr_pkg.sv
// Constants for the probe holding-register bank.
// Assumes a Modbus frame engine outside that issues word reads and writes.
package pmr_pkg;
    localparam logic [15:0] PMR_ADDR_HUM_LO = 16'h0000;
    localparam logic [15:0] PMR_ADDR_HUM_HI = 16'h0001;
    localparam logic [15:0] PMR_ADDR_TEMP_LO = 16'h0002;
    localparam logic [15:0] PMR_ADDR_TEMP_HI = 16'h0003;
    localparam logic [15:0] PMR_ADDR_DEW_LO = 16'h0008;
    localparam logic [15:0] PMR_ADDR_DEW_HI = 16'h0009;
    localparam logic [15:0] PMR_ADDR_FAULT = 16'h0200;
    localparam logic [15:0] PMR_ADDR_ERR_LO = 16'h0203;
    localparam logic [15:0] PMR_ADDR_ERR_HI = 16'h0204;
    localparam logic [15:0] PMR_ADDR_HASH_LO = 16'h0205;
    localparam logic [15:0] PMR_ADDR_HASH_HI = 16'h0206;
    localparam logic [15:0] PMR_ADDR_SMOOTH_LO = 16'h0310;
    localparam logic [15:0] PMR_ADDR_SMOOTH_HI = 16'h0311;
    localparam logic [15:0] PMR_ADDR_NODE = 16'h0600;
    localparam logic [15:0] PMR_ADDR_BAUD = 16'h0601;
    localparam logic [15:0] PMR_ADDR_FRAME = 16'h0602;
    localparam logic [15:0] PMR_ADDR_DELAY = 16'h0603;
    localparam logic [15:0] PMR_ADDR_PROTO = 16'h0604;
    localparam logic [15:0] PMR_ADDR_RESTART = 16'h0605;
    localparam logic [31:0] PMR_QNAN = 32'h7fc00000;
    localparam logic [31:0] PMR_SMOOTH_MIN = 32'h3a83126f;
    localparam logic [31:0] PMR_SMOOTH_MAX = 32'h3f800000;
    localparam logic [31:0] PMR_SMOOTH_RST = 32'h3f800000;
    localparam logic [15:0] PMR_NODE_RST = 16'h00f0;
    localparam logic [15:0] PMR_BAUD_RST = 16'h0005;
    localparam logic [15:0] PMR_FRAME_RST = 16'h0001;
    localparam logic [15:0] PMR_DELAY_RST = 16'h0000;
    localparam logic [15:0] PMR_DELAY_MAX = 16'h03fc;
    localparam logic [15:0] PMR_PROTO_RST = 16'h0006;
    localparam logic [15:0] PMR_BAUD_MAX = 16'h0008;
    localparam logic [15:0] PMR_BAUD_MODBUS_MIN = 16'h0005;
    localparam logic [15:0] PMR_PROTO_MODBUS = 16'h0006;
    localparam logic [15:0] PMR_RESTART_CMD = 16'h0001;
    localparam logic [31:0] PMR_HASH_RST = 32'h00000000;
    localparam logic [31:0] PMR_HASH_STEP = 32'h9e3779b9;
    localparam int PMR_FRAME_SEVEN_BIT = 3;
    localparam int PMR_BAUD_RATE_300 = 300;
    localparam int PMR_BAUD_RATE_600 = 600;
    localparam int PMR_BAUD_RATE_1200 = 1200;
    localparam int PMR_BAUD_RATE_2400 = 2400;
    localparam int PMR_BAUD_RATE_4800 = 4800;
    localparam int PMR_BAUD_RATE_9600 = 9600;
    localparam int PMR_BAUD_RATE_19200 = 19200;
    localparam int PMR_BAUD_RATE_38400 = 38400;
    localparam int PMR_BAUD_RATE_57600 = 57600;
    typedef enum logic [1:0] {
        PMR_PAR_NONE,
        PMR_PAR_EVEN,
        PMR_PAR_ODD
    } pmr_parity_t;
    typedef enum logic [2:0] {
        PMR_PROTO_CMDLINE,
        PMR_PROTO_AUTO,
        PMR_PROTO_POLLED,
        PMR_PROTO_ANALOG,
        PMR_PROTO_RTU,
        PMR_PROTO_INVALID
    } pmr_proto_t;
endpackage

//--- pmr_master_model.sv
// Modbus master model: frames word reads and writes for the register bank.
// Assumes the bench owns sys_clk and rst and calls these tasks after reset.
`timescale 1ns/1ns
module pmr_master_model #(
    parameter int BOOT_WAIT = 20
) (
    input wire logic sys_clk,
    input wire logic rst,
    output logic txn_start,
    output logic txn_end,
    output logic rd_req,
    output logic wr_req,
    output logic [15:0] reg_addr,
    output logic [15:0] wr_data,
    input wire logic rd_valid,
    input wire logic [15:0] rd_data,
    input wire logic wr_reject,
    input wire logic restart_pulse
);
    ////////////////////////////////////////////////////////////////////////
    initial begin
        txn_start = 1'b0;
        txn_end = 1'b0;
        rd_req = 1'b0;
        wr_req = 1'b0;
        reg_addr = 16'h5a5a;
        wr_data = 16'ha5a5;
    end
    // Scaled stand-in for the quiet time after power-up
    task automatic boot_wait();
        repeat (BOOT_WAIT) @(posedge sys_clk iff !rst);
    endtask
    // Both halves of a pair go between one start and one end
    task automatic frame(input bit last);
        @(posedge sys_clk);
        txn_start <= !last;
        txn_end <= last;
        @(posedge sys_clk);
        txn_start <= 1'b0;
        txn_end <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, output logic [15:0] d, output logic v);
        @(posedge sys_clk);
        rd_req <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        rd_req <= 1'b0;
        // Idle bus must not keep a stale address
        reg_addr <= ~a;
        #1;
        v = rd_valid;
        d = rd_data;
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d, output logic rej, output logic rs);
        @(posedge sys_clk);
        wr_req <= 1'b1;
        reg_addr <= a;
        wr_data <= d;
        @(posedge sys_clk);
        wr_req <= 1'b0;
        reg_addr <= ~a;
        wr_data <= ~d;
        #1;
        rej = wr_reject;
        rs = restart_pulse;
    endtask
endmodule

//--- tb.sv
// Self-checking bench for the probe register bank.
// Assumes the master model in pmr_master_model.sv drives the transaction side.
`timescale 1ns/1ns
module tb
    import pmr_pkg::*;
;
    logic sys_clk, rst, meas_valid, rd_valid, wr_reject, restart_pulse;
    logic txn_start, txn_end, rd_req, wr_req, active_seven_bits, active_two_stop, active_modbus_ok;
    logic [15:0] reg_addr, wr_data, rd_data, node_address, reply_delay, rd_d;
    logic [31:0] humidity_in, temperature_in, dew_point_in, error_flags_in;
    logic [3:0] active_baud;
    pmr_parity_t active_parity;
    pmr_proto_t active_protocol;
    logic rd_v, rej, rs;
    int errors, comparisons;
    ////////////////////////////////////////////////////////////////////////
    pmr_regs dut (.sys_clk(sys_clk), .rst(rst), .txn_start(txn_start), .txn_end(txn_end),
        .rd_req(rd_req), .wr_req(wr_req), .reg_addr(reg_addr), .wr_data(wr_data),
        .rd_valid(rd_valid), .rd_data(rd_data), .wr_reject(wr_reject), .humidity_in(humidity_in),
        .temperature_in(temperature_in), .dew_point_in(dew_point_in), .meas_valid(meas_valid),
        .error_flags_in(error_flags_in), .node_address(node_address), .reply_delay(reply_delay),
        .active_baud(active_baud), .active_parity(active_parity), .active_seven_bits(active_seven_bits),
        .active_two_stop(active_two_stop), .active_protocol(active_protocol),
        .active_modbus_ok(active_modbus_ok), .restart_pulse(restart_pulse));
    pmr_master_model mst (.sys_clk(sys_clk), .rst(rst), .txn_start(txn_start), .txn_end(txn_end),
        .rd_req(rd_req), .wr_req(wr_req), .reg_addr(reg_addr), .wr_data(wr_data),
        .rd_valid(rd_valid), .rd_data(rd_data), .wr_reject(wr_reject), .restart_pulse(restart_pulse));
    ////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_flag(input string what, input logic exp, input logic got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic rdc(input logic [15:0] a, input logic [15:0] exp);
        mst.rd(a, rd_d, rd_v);
        chk_flag("read valid", 1'b1, rd_v);
        chk("read data", exp, rd_d);
    endtask
    task automatic wrc(input logic [15:0] a, input logic [15:0] d, input logic exp_rej);
        mst.wr(a, d, rej, rs);
        chk_flag("write reject", exp_rej, rej);
        chk_flag("restart pulse", a == PMR_ADDR_RESTART && d == PMR_RESTART_CMD, rs);
    endtask
    task automatic rd32(input logic [15:0] a, input logic [31:0] exp);
        mst.frame(0);
        rdc(a, exp[15:0]);
        rdc(a + 16'h0001, exp[31:16]);
        mst.frame(1);
    endtask
    // Settings land only on restart; active outputs follow one cycle after the pulse
    task automatic cfg(input logic [15:0] b, input logic [15:0] f, input logic [15:0] p);
        mst.frame(0);
        wrc(PMR_ADDR_BAUD, b, 1'b0);
        wrc(PMR_ADDR_FRAME, f, 1'b0);
        wrc(PMR_ADDR_PROTO, p, 1'b0);
        mst.frame(1);
        wrc(PMR_ADDR_RESTART, PMR_RESTART_CMD, 1'b0);
        @(posedge sys_clk);
        #1;
        chk("baud", b, 16'(active_baud));
        chk_flag("modbus ok", !(p == 16'h0006 && (f[3] || b < 16'h0005)), active_modbus_ok);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    initial begin
        #5000000;
        errors++;
        close_out();
    end
    initial begin
        logic [15:0] rs_a [11] = '{16'h0600, 16'h0601, 16'h0602, 16'h0603, 16'h0604, 16'h0605,
            16'h0310, 16'h0311, 16'h0205, 16'h0206, 16'h0100};
        logic [15:0] rs_e [11] = '{16'h00f0, 16'h0005, 16'h0001, 16'h0000, 16'h0006, 16'h0000,
            16'h0000, 16'h3f80, 16'h0000, 16'h0000, 16'h0000};
        logic [15:0] mp_e [10] = '{16'h0000, 16'h4248, 16'h0000, 16'h41c8, 16'h0000, 16'h0000,
            16'h0000, 16'h0000, 16'h0000, 16'h4120};
        logic [15:0] fr [12] = '{0, 1, 2, 3, 4, 5, 8, 9, 10, 11, 12, 13};
        logic [15:0] pc [6] = '{0, 1, 2, 5, 6, 3};
        pmr_proto_t pe [6] = '{PMR_PROTO_CMDLINE, PMR_PROTO_AUTO, PMR_PROTO_POLLED, PMR_PROTO_ANALOG,
            PMR_PROTO_RTU, PMR_PROTO_INVALID};
        errors = 0;
        comparisons = 0;
        rst = 1'b1;
        meas_valid = 1'b1;
        humidity_in = 32'h42480000;
        temperature_in = 32'h41c80000;
        dew_point_in = 32'h41200000;
        error_flags_in = 32'h00000000;
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        mst.boot_wait();
        mst.frame(0);
        for (int i = 0; i < 11; i++) rdc(rs_a[i], rs_e[i]);
        rdc(PMR_ADDR_FAULT, 16'h0001);
        for (int i = 0; i < 10; i++) rdc(16'(i), mp_e[i]);
        mst.frame(1);
        // Pair snapshot keeps the high half coherent across a live change
        mst.frame(0);
        rdc(PMR_ADDR_TEMP_LO, 16'h0000);
        @(posedge sys_clk);
        temperature_in <= 32'h42000000;
        rdc(PMR_ADDR_TEMP_HI, 16'h41c8);
        mst.frame(1);
        @(posedge sys_clk);
        meas_valid <= 1'b0;
        rd32(PMR_ADDR_TEMP_LO, PMR_QNAN);
        rd32(PMR_ADDR_HUM_LO, PMR_QNAN);
        @(posedge sys_clk);
        meas_valid <= 1'b1;
        error_flags_in <= 32'h80000001;
        humidity_in <= 32'h42c80000;
        dew_point_in <= 32'hc1200000;
        rd32(PMR_ADDR_HUM_LO, 32'h42c80000);
        rd32(PMR_ADDR_DEW_LO, 32'hc1200000);
        mst.frame(0);
        wrc(PMR_ADDR_TEMP_LO, 16'h1234, 1'b1);
        wrc(PMR_ADDR_ERR_LO, 16'hffff, 1'b1);
        rdc(PMR_ADDR_ERR_LO, 16'h0001);
        rdc(PMR_ADDR_ERR_HI, 16'h8000);
        rdc(PMR_ADDR_FAULT, 16'h0000);
        rdc(PMR_ADDR_TEMP_LO, 16'h0000);
        wrc(PMR_ADDR_NODE, 16'h0011, 1'b0);
        wrc(PMR_ADDR_DELAY, 16'h03fd, 1'b0);
        wrc(16'h0700, 16'h0001, 1'b0);
        rdc(PMR_ADDR_NODE, 16'h0011);
        chk("node out", 16'h0011, node_address);
        chk("delay out", PMR_DELAY_MAX, reply_delay);
        rdc(PMR_ADDR_DELAY, 16'h03fd);
        mst.frame(1);
        mst.frame(0);
        wrc(PMR_ADDR_SMOOTH_LO, 16'h0000, 1'b0);
        wrc(PMR_ADDR_SMOOTH_HI, 16'h3f00, 1'b0);
        mst.frame(1);
        rd32(PMR_ADDR_SMOOTH_LO, 32'h3f000000);
        mst.frame(0);
        mst.rd(PMR_ADDR_HASH_LO, rd_d, rd_v);
        rej = rd_d !== 16'h0000;
        mst.rd(PMR_ADDR_HASH_HI, rd_d, rd_v);
        chk_flag("hash changed", 1'b1, rej || rd_d !== 16'h0000);
        wrc(PMR_ADDR_SMOOTH_LO, 16'h0000, 1'b0);
        wrc(PMR_ADDR_SMOOTH_HI, 16'h4000, 1'b0);
        mst.frame(1);
        mst.frame(0);
        wrc(PMR_ADDR_SMOOTH_HI, 16'h3e80, 1'b0);
        mst.frame(1);
        rd32(PMR_ADDR_SMOOTH_LO, 32'h3f000000);
        // Stored setting is readable at once but stays dormant until restart
        mst.frame(0);
        wrc(PMR_ADDR_BAUD, 16'h0007, 1'b0);
        wrc(PMR_ADDR_RESTART, 16'h0002, 1'b0);
        rdc(PMR_ADDR_BAUD, 16'h0007);
        mst.frame(1);
        chk("baud held", 16'h0005, 16'(active_baud));
        for (int b = 0; b < 9; b++) cfg(16'(b), 16'h0001, 16'h0006);
        for (int i = 0; i < 12; i++) begin
            cfg(16'h0006, fr[i], 16'h0006);
            chk_flag("two stop", fr[i][0], active_two_stop);
            chk_flag("seven bits", fr[i][3], active_seven_bits);
            chk("parity", 16'(fr[i][2:1]), 16'(active_parity));
        end
        for (int i = 0; i < 6; i++) begin
            cfg(16'h0005, 16'h0001, pc[i]);
            chk("protocol", 16'(pe[i]), 16'(active_protocol));
        end
        close_out();
    end
endmodule
